// file: integrity_pkg.sv
// Constants, register map and types for the run-time memory integrity checker
package integrity_pkg;
  localparam int NUM_BLOCKS = 4;
  localparam int NUM_SEGS = 8;
  localparam logic [1:0] LAST_BLOCK = 2'h3;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_THROTTLE = 8'h04;
  localparam logic [7:0] OFS_WATCHDOG = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [1:0] SEG_PAGE = 2'h1;
  localparam logic [3:0] HASH_PAGE = 4'h8;
  // Control fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_ALG_BIT = 4;
  localparam int CTRL_SWAP_BIT = 5;
  localparam int CTRL_IRQ_EN_BIT = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] THROTTLE_RESET = 32'h0000_0000;
  localparam logic [31:0] WATCHDOG_RESET = 32'h0000_0000;
  // Command bits
  localparam int CMD_ONCE_BIT = 0;
  localparam int CMD_RUN_BIT = 1;
  localparam int CMD_SWRST_BIT = 2;
  localparam int CMD_CLRIRQ_BIT = 3;
  // Scan geometry
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [7:0] CHUNK_WORDS = 8'h10;
  // Hash seeds and mixing constants per algorithm
  localparam logic [31:0] SEED_256 = 32'h6a09_e667;
  localparam logic [31:0] SEED_512 = 32'hcbbb_9d5d;
  localparam logic [31:0] MIX_256 = 32'h428a_2f98;
  localparam logic [31:0] MIX_512 = 32'hd728_ae22;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BLOCK = 3'b001,
    ST_SEG = 3'b010,
    ST_READ = 3'b011,
    ST_PAUSE = 3'b100,
    ST_CHECK = 3'b101,
    ST_ERROR = 3'b110
  } scan_state_t;
endpackage : integrity_pkg

// file: digest_core.sv
// Word-serial digest accumulator with algorithm and byte-order select
`timescale 1ns/1ps
module digest_core (
  input wire logic clock,
  input wire logic rst,
  input wire logic init,
  input wire logic feed,
  input wire logic [31:0] word,
  input wire logic alg_wide,
  input wire logic swap_bytes,
  output logic [31:0] digest
);
  import integrity_pkg::*;
  logic [31:0] digest_r;
  logic [31:0] word_in;
  logic [31:0] mix;

  assign word_in = swap_bytes ? {word[7:0], word[15:8], word[23:16], word[31:24]} : word;
  assign mix = alg_wide ? MIX_512 : MIX_256;
  assign digest = digest_r;

  // Hash algorithm selects the seed and mixing constant
  always_ff @(posedge clock) begin
    if (rst) begin
      digest_r <= SEED_256;
    end else if (init) begin
      digest_r <= alg_wide ? SEED_512 : SEED_256;
    end else if (feed) begin
      digest_r <= {digest_r[26:0], digest_r[31:27]} ^ (word_in + mix + digest_r);
    end
  end
endmodule : digest_core

// file: access_watchdog.sv
// Watchdog that expires while a memory read waits too long for data
`timescale 1ns/1ps
module access_watchdog (
  input wire logic clock,
  input wire logic rst,
  input wire logic [31:0] limit,
  input wire logic waiting,
  input wire logic kick,
  output logic expired
);
  logic [31:0] count_r;
  logic expired_r;

  assign expired = expired_r;

  // A limit of zero disables the watchdog
  always_ff @(posedge clock) begin
    if (rst || !waiting || kick) begin
      count_r <= 32'h0000_0000;
    end else if (count_r != limit) begin
      count_r <= count_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      expired_r <= 1'b0;
    end else begin
      expired_r <= waiting && !kick && (limit != 32'h0000_0000) && (count_r == limit);
    end
  end
endmodule : access_watchdog

// file: integrity_checker.sv
// Run-time memory integrity checker: registers, scan sequencer and read path
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module integrity_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic dma_req,
  output logic [31:0] dma_addr,
  input wire logic dma_valid,
  input wire logic [31:0] dma_rdata,
  input wire logic dma_err,
  output logic irq,
  output logic security_violation
);
  import integrity_pkg::*;

  logic [31:0] ctrl_r;
  logic [31:0] throttle_r;
  logic [31:0] watchdog_r;
  logic [31:0] seg_addr_r [NUM_SEGS];
  logic [31:0] seg_len_r [NUM_SEGS];
  logic [31:0] ref_hash_r [NUM_BLOCKS];
  scan_state_t state_r;
  logic [1:0] blk_r;
  logic seg_r;
  logic run_mode_r;
  logic [31:0] rem_r;
  logic [31:0] addr_r;
  logic dma_req_r;
  logic [7:0] chunk_r;
  logic [31:0] pause_r;
  logic done_pend_r;
  logic err_pend_r;
  logic [3:0] err_cause_r;
  logic irq_r;
  logic viol_r;
  logic [31:0] rdata_r;
  logic swrst_pend_r;

  logic cmd_wr;
  logic seg_sel;
  logic hash_sel;
  logic [2:0] seg_idx;
  logic [2:0] cur_idx;
  logic [31:0] cur_len;
  logic [31:0] cur_addr;
  logic blk_enabled;
  logic start_once;
  logic start_run;
  logic sw_reset;
  logic clear_irq;
  logic hash_init;
  logic hash_feed;
  logic [31:0] digest;
  logic wd_expired;
  logic beat;
  logic last_beat;
  logic bad_seg;
  logic mismatch;
  logic fault;
  logic pass_done;
  logic pass_end;
  logic swrst_go;

  assign reg_rdata = rdata_r;
  assign dma_req = dma_req_r;
  assign dma_addr = addr_r;
  assign irq = irq_r;
  assign security_violation = viol_r;

  assign cmd_wr = reg_wr && (reg_addr == OFS_CMD);
  assign seg_sel = (reg_addr[7:6] == SEG_PAGE);
  assign hash_sel = (reg_addr[7:4] == HASH_PAGE);
  assign seg_idx = reg_addr[5:3];
  assign start_once = cmd_wr && reg_wdata[CMD_ONCE_BIT];
  assign start_run = cmd_wr && reg_wdata[CMD_RUN_BIT];
  assign sw_reset = cmd_wr && reg_wdata[CMD_SWRST_BIT];
  assign clear_irq = cmd_wr && reg_wdata[CMD_CLRIRQ_BIT];

  // Segment 0 of a block sits at the even index, segment 1 at the odd one
  assign cur_idx = {blk_r, seg_r};
  assign cur_len = seg_len_r[cur_idx];
  assign cur_addr = seg_addr_r[cur_idx];
  assign blk_enabled = ctrl_r[CTRL_EN_LSB + 32'(blk_r)];
  assign bad_seg = (cur_len[1:0] != 2'b00) || (cur_addr[1:0] != 2'b00);
  assign beat = (state_r == ST_READ) && dma_req_r && dma_valid;
  assign last_beat = beat && !dma_err && (rem_r == WORD_BYTES);
  assign mismatch = (state_r == ST_CHECK) && run_mode_r && (digest != ref_hash_r[blk_r]);
  assign pass_done = (blk_r == LAST_BLOCK);
  assign hash_init = (state_r == ST_BLOCK) && blk_enabled;
  assign hash_feed = beat && !dma_err;
  // A one-time pass also ends when the last block is disabled
  assign pass_end = !run_mode_r && pass_done
                    && (state_r == ST_CHECK || (state_r == ST_BLOCK && !blk_enabled));
  // Software reset waits for an unanswered read so the request never vanishes
  assign swrst_go = (sw_reset || swrst_pend_r) && !(dma_req_r && !dma_valid);

  // Every fault source that ends scanning
  always_comb begin
    fault = 1'b0;
    if (state_r == ST_SEG && cur_len != 32'h0000_0000 && bad_seg) begin
      fault = 1'b1;
    end
    if ((beat && dma_err) || wd_expired || mismatch) begin
      fault = 1'b1;
    end
  end

  digest_core u_digest (
    .clock(clock),
    .rst(rst),
    .init(hash_init),
    .feed(hash_feed),
    .word(dma_rdata),
    .alg_wide(ctrl_r[CTRL_ALG_BIT]),
    .swap_bytes(ctrl_r[CTRL_SWAP_BIT]),
    .digest(digest)
  );

  access_watchdog u_watchdog (
    .clock(clock),
    .rst(rst),
    .limit(watchdog_r),
    .waiting(dma_req_r && state_r == ST_READ),
    .kick(dma_valid),
    .expired(wd_expired)
  );

  // Configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
      throttle_r <= THROTTLE_RESET;
      watchdog_r <= WATCHDOG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      if (reg_addr == OFS_THROTTLE) begin
        throttle_r <= reg_wdata;
      end
      if (reg_addr == OFS_WATCHDOG) begin
        watchdog_r <= reg_wdata;
      end
    end
  end

  // Segment address and length pairs
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_SEGS; i++) begin
        seg_addr_r[i] <= 32'h0000_0000;
        seg_len_r[i] <= 32'h0000_0000;
      end
    end else if (reg_wr && seg_sel) begin
      if (reg_addr[2]) begin
        seg_len_r[seg_idx] <= reg_wdata;
      end else begin
        seg_addr_r[seg_idx] <= reg_wdata;
      end
    end
  end

  // Reference hash file, loaded only by one-time passes
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        ref_hash_r[i] <= 32'h0000_0000;
      end
    end else if (state_r == ST_CHECK && !run_mode_r) begin
      ref_hash_r[blk_r] <= digest;
    end
  end

  // Scan sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
      blk_r <= 2'h0;
      seg_r <= 1'b0;
      run_mode_r <= 1'b0;
      rem_r <= 32'h0000_0000;
      addr_r <= 32'h0000_0000;
      dma_req_r <= 1'b0;
      chunk_r <= 8'h00;
      pause_r <= 32'h0000_0000;
    end else if (fault || state_r == ST_ERROR) begin
      state_r <= ST_ERROR;
      dma_req_r <= 1'b0;
    end else if (swrst_go) begin
      state_r <= ST_IDLE;
      dma_req_r <= 1'b0;
      run_mode_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_once || start_run) begin
            run_mode_r <= start_run;
            blk_r <= 2'h0;
            state_r <= ST_BLOCK;
          end
        end
        ST_BLOCK: begin
          seg_r <= 1'b0;
          if (blk_enabled) begin
            state_r <= ST_SEG;
          end else if (pass_done) begin
            blk_r <= 2'h0;
            state_r <= run_mode_r ? ST_BLOCK : ST_IDLE;
          end else begin
            blk_r <= blk_r + 2'h1;
          end
        end
        ST_SEG: begin
          if (cur_len == 32'h0000_0000) begin
            seg_r <= 1'b1;
            if (seg_r) begin
              state_r <= ST_CHECK;
            end
          end else begin
            rem_r <= cur_len;
            addr_r <= cur_addr;
            chunk_r <= 8'h00;
            dma_req_r <= 1'b1;
            state_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (beat) begin
            rem_r <= rem_r - WORD_BYTES;
            addr_r <= addr_r + WORD_BYTES;
            chunk_r <= chunk_r + 8'h01;
            if (last_beat) begin
              dma_req_r <= 1'b0;
              seg_r <= 1'b1;
              state_r <= seg_r ? ST_CHECK : ST_SEG;
            end else if (run_mode_r && chunk_r == CHUNK_WORDS - 8'h01
                         && throttle_r != 32'h0000_0000) begin
              dma_req_r <= 1'b0;
              pause_r <= throttle_r;
              chunk_r <= 8'h00;
              state_r <= ST_PAUSE;
            end
          end
        end
        ST_PAUSE: begin
          if (pause_r == 32'h0000_0001) begin
            dma_req_r <= 1'b1;
            state_r <= ST_READ;
          end else begin
            pause_r <= pause_r - 32'h0000_0001;
          end
        end
        ST_CHECK: begin
          if (pass_done) begin
            blk_r <= 2'h0;
            state_r <= run_mode_r ? ST_BLOCK : ST_IDLE;
          end else begin
            blk_r <= blk_r + 2'h1;
            state_r <= ST_BLOCK;
          end
        end
        ST_ERROR: begin
          state_r <= ST_ERROR;
        end
        default: begin
          state_r <= ST_ERROR;
        end
      endcase
    end
  end

  // Software reset held until the outstanding word arrives
  always_ff @(posedge clock) begin
    if (rst) begin
      swrst_pend_r <= 1'b0;
    end else begin
      swrst_pend_r <= (sw_reset || swrst_pend_r) && !swrst_go;
    end
  end

  // Completion flag: a one-time pass ending wins over a clear in that cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      done_pend_r <= 1'b0;
    end else if (pass_end && !fault) begin
      done_pend_r <= 1'b1;
    end else if (clear_irq) begin
      done_pend_r <= 1'b0;
    end
  end

  // Error flag and cause bits
  always_ff @(posedge clock) begin
    if (rst) begin
      err_pend_r <= 1'b0;
      err_cause_r <= 4'h0;
    end else begin
      if (fault && state_r != ST_ERROR) begin
        err_pend_r <= 1'b1;
        err_cause_r <= err_cause_r | {mismatch, wd_expired, beat && dma_err,
                                      state_r == ST_SEG};
      end else if (clear_irq) begin
        err_pend_r <= 1'b0;
      end
    end
  end

  // Violation stays high from the fault onward; only rst clears it
  always_ff @(posedge clock) begin
    if (rst) begin
      viol_r <= 1'b0;
    end else if (fault || state_r == ST_ERROR) begin
      viol_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ctrl_r[CTRL_IRQ_EN_BIT] && (done_pend_r || err_pend_r);
    end
  end

  // Read port, data valid the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        rdata_r <= ctrl_r;
      end else if (reg_addr == OFS_THROTTLE) begin
        rdata_r <= throttle_r;
      end else if (reg_addr == OFS_WATCHDOG) begin
        rdata_r <= watchdog_r;
      end else if (reg_addr == OFS_STATUS) begin
        rdata_r <= {23'h000000, run_mode_r, err_cause_r, state_r == ST_ERROR,
                    err_pend_r, done_pend_r,
                    state_r != ST_IDLE && state_r != ST_ERROR};
      end else if (seg_sel) begin
        rdata_r <= reg_addr[2] ? seg_len_r[seg_idx] : seg_addr_r[seg_idx];
      end else if (hash_sel) begin
        rdata_r <= ref_hash_r[reg_addr[3:2]];
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // The memory path carries no write strobe or write data at all
endmodule : integrity_checker

// file: integrity_checker_chk.sv
// Port assertions for the run-time memory integrity checker
`timescale 1ns/1ps
module integrity_checker_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic dma_valid,
  input wire logic [31:0] dma_rdata,
  input wire logic dma_err,
  input wire logic irq,
  input wire logic security_violation
);
  import integrity_pkg::*;
  logic ien_r;
  logic [31:0] wd_r;
  logic [31:0] stall_r;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Mirrors of the interrupt enable and watchdog limit as written by software
  always_ff @(posedge clock) begin
    if (rst) ien_r <= 1'b0;
    else if (reg_wr && reg_addr == OFS_CTRL) ien_r <= reg_wdata[CTRL_IRQ_EN_BIT];
  end
  always_ff @(posedge clock) begin
    if (rst) wd_r <= 32'h0;
    else if (reg_wr && reg_addr == OFS_WATCHDOG) wd_r <= reg_wdata;
  end
  always_ff @(posedge clock) begin
    if (rst || !(dma_req && !dma_valid)) stall_r <= 32'h0;
    else stall_r <= stall_r + 32'h1;
  end
  sequence s_word;
    dma_req && dma_valid && !dma_err;
  endsequence
  sequence s_fault;
    dma_req && dma_valid && dma_err;
  endsequence
  addr_aligned_a: assert property (dma_req |-> dma_addr[1:0] == 2'h0)
    else $error("read address not word aligned");
  addr_step_a: assert property (s_word ##1 dma_req |-> dma_addr == $past(dma_addr) + WORD_BYTES)
    else $error("read address did not advance by one word");
  req_hold_a: assert property (dma_req && !dma_valid |=>
    security_violation || (dma_req && $stable(dma_addr)))
    else $error("read request dropped or changed unanswered");
  err_viol_a: assert property (s_fault |=> security_violation)
    else $error("read error did not raise violation");
  viol_sticky_a: assert property (security_violation |=> security_violation)
    else $error("violation released without reset");
  halt_state_a: assert property (security_violation |=> !dma_req)
    else $error("memory read while halted");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  err_status_a: assert property (reg_rd && reg_addr == OFS_STATUS && security_violation
    |=> reg_rdata[3])
    else $error("status misses error state");
  irq_gate_a: assert property (irq |-> $past(ien_r))
    else $error("interrupt while disabled");
  wd_bound_a: assert property (dma_req && !dma_valid && wd_r != 0 |->
    stall_r <= wd_r + 32'h2)
    else $error("watchdog did not expire");
endmodule : integrity_checker_chk
bind integrity_checker integrity_checker_chk u_chk (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_addr(dma_addr), .dma_valid(dma_valid),
  .dma_rdata(dma_rdata), .dma_err(dma_err), .irq(irq), .security_violation(security_violation));

// file: mem_model.sv
// Behavioural system memory answering read requests
`timescale 1ns/1ps
module mem_model (
  input wire logic clock,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic hold,
  input wire logic stall,
  input wire logic fail,
  input wire logic flip,
  output logic dma_valid,
  output logic [31:0] dma_rdata,
  output logic dma_err
);
  logic [31:0] last_r = 32'h0;
  logic [31:0] log[$];
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return (a * 32'h9e37_79b9) ^ 32'h5a5a_0f0f;
  endfunction : word_at
  assign dma_valid = dma_req && !hold && !stall;
  assign dma_err = dma_valid && fail;
  // Idle data shows the inverse of the last word, never a stale copy
  assign dma_rdata = dma_valid ? word_at(dma_addr) ^ {32{flip}} : ~last_r;
  always @(posedge clock) begin
    if (dma_valid) begin
      last_r <= dma_rdata;
      log.push_back(dma_addr);
    end
  end
endmodule : mem_model

// file: integrity_checker_tb.sv
// Self-checking bench for the run-time memory integrity checker
`timescale 1ns/1ps
module integrity_checker_tb;
  import integrity_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, dma_addr, dma_rdata, d;
  logic dma_req, dma_valid, dma_err, irq, security_violation;
  logic hold = 1'b0;
  logic stall = 1'b0;
  logic fail = 1'b0;
  logic flip = 1'b0;
  logic [3:0] en;
  int seed = 78449;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] sa[8];
  logic [31:0] sl[8];
  logic [31:0] h[2];
  logic [31:0] exp_q[$];
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h8c, 8'h20};
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) hold <= 1'($random(seed));
  integrity_checker DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_valid(dma_valid), .dma_rdata(dma_rdata),
    .dma_err(dma_err), .irq(irq), .security_violation(security_violation));
  mem_model mem (.clock(clock), .dma_req(dma_req), .dma_addr(dma_addr), .hold(hold),
    .stall(stall), .fail(fail), .flip(flip), .dma_valid(dma_valid), .dma_rdata(dma_rdata),
    .dma_err(dma_err));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic wait_bit(input int b);
    for (int i = 0; i < 400; i++) begin
      rd(OFS_STATUS);
      if (d[b] === 1'b1) return;
    end
    chk(d, 32'h1 << b);
    tally_and_finish();
  endtask : wait_bit
  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset
  task automatic setup();
    for (int i = 0; i < NUM_SEGS; i++) begin
      sa[i] = (32'(i) << 12) | (32'($random(seed)) & 32'hffc);
      sl[i] = (i == 0) ? 32'h80 : (i == 1) ? 32'h0 : 32'($random(seed)) & 32'h3c;
      wr(8'h40 + 8'(8 * i), sa[i]);
      wr(8'h44 + 8'(8 * i), sl[i]);
    end
  endtask : setup
  // Expected read addresses: enabled blocks in order, segment 0 then 1
  function automatic void plan();
    exp_q.delete();
    for (int b = 0; b < NUM_BLOCKS; b++)
      for (int s = 0; s < 2; s++)
        for (int w = 0; w < sl[2 * b + s] / 4; w++)
          if (en[b]) exp_q.push_back(sa[2 * b + s] + 32'(4 * w));
  endfunction : plan
  initial begin
    do_reset();
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(d, 32'h0);
    end
    $display("test reset values done");
    for (int r = 0; r < 2; r++) begin
      en = r ? 4'hf : 4'($random(seed)) | 4'h1;
      wr(OFS_CTRL, {25'h0, r[0], r[0], r[0], en});
      wr(OFS_THROTTLE, 32'h0);
      if (r == 0) setup();
      plan();
      mem.log.delete();
      wr(OFS_CMD, 32'h1);
      wait_bit(1);
      chk(32'(mem.log.size()), 32'(exp_q.size()));
      foreach (exp_q[i]) chk(mem.log[i], exp_q[i]);
      repeat (2) @(posedge clock);
      #1 chk(32'(irq), 32'(r));
      rd(8'h80);
      h[r] = d;
      wr(8'h80, ~d);
      rd(8'h80);
      chk(d, h[r]);
      wr(OFS_CMD, 32'h8);
      rd(OFS_STATUS);
      chk(32'({d[1], irq}), 32'h0);
    end
    chk(32'(h[0] !== h[1]), 32'h1);
    $display("test one-time hashing done");
    wr(OFS_CTRL, 32'h7f);
    wr(OFS_THROTTLE, (32'($random(seed)) & 32'h7) | 32'h1);
    wr(OFS_WATCHDOG, 32'h40);
    mem.log.delete();
    wr(OFS_CMD, 32'h2);
    for (int i = 0; i < 3000 && mem.log.size() <= 2 * exp_q.size(); i++) @(posedge clock);
    chk(32'(mem.log.size() > 2 * exp_q.size()), 32'h1);
    if (n_mismatch != 0) tally_and_finish();
    for (int i = 0; i < 2 * exp_q.size(); i++) chk(mem.log[i], exp_q[i % exp_q.size()]);
    rd(OFS_STATUS);
    chk(32'({d[8], d[3], irq, security_violation}), 32'h8);
    wr(OFS_CMD, 32'h4);
    for (int i = 0; i < 40 && d[0]; i++) rd(OFS_STATUS);
    chk(32'({d[8], d[0]}), 32'h0);
    wr(OFS_CMD, 32'h2);
    flip <= 1'b1;
    wait_bit(3);
    repeat (2) @(posedge clock);
    #1 chk(32'({d[7], irq, security_violation}), 32'h7);
    flip <= 1'b0;
    wr(OFS_CMD, 32'h4);
    wr(OFS_CMD, 32'h2);
    rd(OFS_STATUS);
    chk(32'({d[3], security_violation}), 32'h3);
    $display("test run-time checking done");
    for (int k = 0; k < 3; k++) begin
      do_reset();
      chk(32'(security_violation), 32'h0);
      fail <= (k == 0);
      stall <= (k == 1);
      wr(OFS_WATCHDOG, 32'h14);
      wr(OFS_CTRL, 32'h41);
      wr(8'h40, 32'h200);
      wr(8'h44, (k == 2) ? 32'h6 : 32'h40);
      wr(OFS_CMD, 32'h1);
      wait_bit(3);
      chk(32'({d[(k == 2) ? 4 : 5 + k], security_violation}), 32'h3);
    end
    fail <= 1'b0;
    stall <= 1'b0;
    $display("test fault handling done");
    tally_and_finish();
  end
endmodule : integrity_checker_tb
